// ===== rtl/acl_l2_match_indirect_bytes.sv
/*
 * Indirect access to the per-port ACL layer-2 match bytes: control,
 * offset and data registers on the switch's byte-wide register port.
 * The control register carries a table code in its upper bits and a
 * port number, counted from one, in its lower nibble. The offset
 * register names one byte of that port's rule, and the data register
 * then reads or writes the byte so named.
 * Only the station address bytes and the EtherType upper byte are kept
 * here; every other offset reads zero and drops writes.
 * A registered copy of every stored byte goes to the matching engine.
 * Assumes a synchronous register port: one-cycle wr or rd strobes with
 * address and write data, answered by rdata one cycle later.
 * Assumes the clock enable is low only while the whole switch core is
 * held; an access made in such a cycle is lost, not delayed.
 * Assumes software has a single outstanding read at a time; the read
 * data register holds its value until the next read is taken.
 * A read and a data write in one cycle both act, and the read sees the
 * byte from before the write.
 */
`timescale 1ns/1ps
`include "acl_l2_defines.svh"

// Operation
// RULE1 - Software writes table select bits 7:5 with the ACL code first.
// RULE2 - Software writes port number one to four into control bits 3:0.
// RULE3 - Offset register byte picks the rule byte shown through data register.
// RULE4 - Offset 0x05 holds MAC bits 23:16, read/write, resets to zero.
// RULE5 - Offset 0x06 holds MAC bits 15:8, read/write, resets to zero.
// RULE6 - Offset 0x07 holds MAC bits 7:0, read/write, resets to zero.
// RULE7 - Offset 0x08 holds EtherType upper byte, read/write.
// RULE8 - Software keeps layer 2, 3 and 4 fields in separate entries.
// RULE9 - Data register write stores the byte; data read returns stored byte.
module acl_l2_match_indirect_bytes
    import acl_l2_pkg::*;
#(
    parameter int NUM_PORTS = 4
) (
    // Clock, reset and enable
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       clk_en_in,
    // Register port
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    output logic            reg_rvalid_out,
    // Stored match bytes, to the matching engine
    output logic [NUM_PORTS*32-1:0] rules_out
);

    // Port field is four bits, so at most fifteen ports can be named
    if (NUM_PORTS < 1 || NUM_PORTS > 15) begin : g_bad_ports
        $error("NUM_PORTS must be 1 to 15");
    end

    // Each port owns one 32-bit slice of rules_out, so a rule is four bytes
    if ($bits(l2_rule_s) != 32) begin : g_bad_rule
        $error("l2_rule_s must be 32 bits wide");
    end

    // Access order seen from software: control, then offset, then data.
    // Control and offset stay put, so a run of data accesses to one byte
    // needs the setup only once. Nothing checks that the setup came first:
    // a data access simply uses whatever selection stands at that moment.
    // Selection changes take effect on the very next cycle, so back-to-back
    // setup and data accesses are safe.

    // Request bundle and its decoded strobes
    reg_req_s   req;
    logic       ctrl_wr;
    logic       offset_wr;
    logic       data_wr;
    logic       rd_take;
    // Control and offset registers, read answer
    logic [7:0] ctrl_q;
    logic [7:0] offset_q;
    logic [7:0] data_byte;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    // Decoded selection
    logic [3:0] port_num;
    logic       acl_sel;
    logic       port_ok;
    // Per-port stores and the selected one
    logic [NUM_PORTS-1:0]     port_wr;
    l2_rule_s [NUM_PORTS-1:0] rule;
    l2_rule_s                 cur_rule;
    logic [NUM_PORTS*32-1:0]  rules_q;

    assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

    // Register strobes; the enable is folded in so that a frozen cycle
    // can neither write a register nor start a read answer
    assign ctrl_wr   = clk_en_in && req.wr && req.addr == `ADDR_TABLE_PORT_SEL;
    assign offset_wr = clk_en_in && req.wr && req.addr == `ADDR_BYTE_OFFSET;
    assign rd_take   = clk_en_in && req.rd;
    // Data strobe left unqualified: each port store gates it with the enable
    assign data_wr   = req.wr && req.addr == `ADDR_BYTE_DATA;

    // RULE1 table select decode
    assign acl_sel  = ctrl_q[`TSEL_MSB:`TSEL_LSB] == `TSEL_ACL;
    // RULE2 port select, numbered from one; zero and numbers past the
    // last port select nothing, so a stray number cannot alias a port
    assign port_num = ctrl_q[`PORT_MSB:`PORT_LSB];
    assign port_ok  = port_num != 4'h0 && 32'(port_num) <= NUM_PORTS;

    // Control register: table select and port; kept whole so that
    // software reads back exactly what it wrote
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q <= `RST_CTRL;
        end else if (ctrl_wr) begin
            ctrl_q <= req.wdata;
        end
    end

    // RULE3 offset register keeps all eight bits, even for offsets
    // that select no byte here, so a read-back shows the true value
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            offset_q <= `RST_CTRL;
        end else if (offset_wr) begin
            offset_q <= req.wdata;
        end
    end

    // RULE9 data write lands in the selected port only; under a refused
    // table or port it reaches no store and is dropped
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            port_wr[i] = data_wr && acl_sel && port_ok && 32'(port_num) == i + 1;
        end
    end

    // One rule store per port; control port number p+1 reaches slice p
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        acl_l2_port_rule u_rule (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .clk_en_in  (clk_en_in),
            .wr_in      (port_wr[p]),
            .offset_in  (offset_q),
            .wdata_in   (req.wdata),
            .rule_out   (rule[p])
        );
    end

    // Selected port's bytes; an invalid port reads as zero rather than
    // as some other port's rule
    always_comb begin
        cur_rule = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (port_ok && 32'(port_num) == i + 1) begin
                cur_rule = rule[i];
            end
        end
    end

    // RULE3 rule byte named by the offset register; offsets kept
    // elsewhere and a foreign table read zero
    always_comb begin
        data_byte = 8'h00;
        if (acl_sel) begin
            unique case (offset_q)
                `OFS_MAC_HI:   data_byte = cur_rule.mac_hi;
                `OFS_MAC_MID:  data_byte = cur_rule.mac_mid;
                `OFS_MAC_LO:   data_byte = cur_rule.mac_lo;
                `OFS_ETYPE_HI: data_byte = cur_rule.etype_hi;
                default:       data_byte = 8'h00;
            endcase
        end
    end

    // RULE9 read mux; unknown addresses read zero. A read in the same
    // cycle as a data write returns the byte from before that write
    always_comb begin
        rdata_d = 8'h00;
        unique case (req.addr)
            `ADDR_TABLE_PORT_SEL: rdata_d = ctrl_q;
            `ADDR_BYTE_OFFSET:    rdata_d = offset_q;
            `ADDR_BYTE_DATA:      rdata_d = data_byte;
            default:              rdata_d = 8'h00;
        endcase
    end

    // Read answer strobe: high for one cycle after each taken read
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rvalid_q <= 1'b0;
        end else if (clk_en_in) begin
            rvalid_q <= rd_take;
        end
    end

    // Read data: captured on a taken read and held until the next one,
    // so slow software may fetch it late
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= 8'h00;
        end else if (rd_take) begin
            rdata_q <= rdata_d;
        end
    end

    // Rule bytes registered toward the matcher so outputs come from flops;
    // costs a flop per stored bit and one cycle of lag after a write
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rules_q <= '0;
        end else if (clk_en_in) begin
            rules_q <= rule;
        end
    end

    // Outputs straight from their flops
    assign reg_rdata_out  = rdata_q;
    assign reg_rvalid_out = rvalid_q;
    assign rules_out      = rules_q;

endmodule // acl_l2_match_indirect_bytes

// ===== rtl/acl_l2_defines.svh
/*
 * Register addresses, field positions, codes and reset values for the
 * indirect ACL layer-2 match byte bank. Definitions only.
 */
`ifndef ACL_L2_DEFINES_SVH
`define ACL_L2_DEFINES_SVH

// Directly addressed switch registers
`define ADDR_TABLE_PORT_SEL   8'h6e
`define ADDR_BYTE_OFFSET      8'h6f
`define ADDR_BYTE_DATA        8'ha0

// Table-select and port fields of the control register
`define TSEL_MSB              7
`define TSEL_LSB              5
`define TSEL_ACL              3'h2
`define PORT_MSB              3
`define PORT_LSB              0

// Rule byte offsets held here
`define OFS_MAC_HI            8'h05
`define OFS_MAC_MID           8'h06
`define OFS_MAC_LO            8'h07
`define OFS_ETYPE_HI          8'h08

// Reset values
`define RST_RULE_BYTE         8'h00
`define RST_CTRL              8'h00

`endif

// ===== rtl/acl_l2_pkg.sv
/*
 * Types shared by the ACL layer-2 byte bank.
 * Assumes nothing of its surroundings.
 */
package acl_l2_pkg;

    // One port's four layer-2 match bytes
    typedef struct packed {
        logic [7:0] mac_hi;
        logic [7:0] mac_mid;
        logic [7:0] mac_lo;
        logic [7:0] etype_hi;
    } l2_rule_s;

    // One register bus access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage

// ===== rtl/acl_l2_port_rule.sv
/*
 * Layer-2 match bytes of one port's ACL rule.
 * Assumes the parent decodes table and port into one-cycle strobes; the offset is decoded here.
 */
`timescale 1ns/1ps
`include "acl_l2_defines.svh"

module acl_l2_port_rule
    import acl_l2_pkg::*;
(
    // Clock, reset and enable
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       clk_en_in,
    // Byte write
    input  wire logic       wr_in,
    input  wire logic [7:0] offset_in,
    input  wire logic [7:0] wdata_in,
    // Stored bytes
    output l2_rule_s        rule_out
);

    // One flop byte per field, each written by its own process
    logic [7:0] mac_hi_q;
    logic [7:0] mac_mid_q;
    logic [7:0] mac_lo_q;
    logic [7:0] etype_hi_q;

    // RULE4 MAC bits 23:16
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mac_hi_q <= `RST_RULE_BYTE;
        end else if (clk_en_in && wr_in && offset_in == `OFS_MAC_HI) begin
            mac_hi_q <= wdata_in;
        end
    end

    // RULE5 MAC bits 15:8
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mac_mid_q <= `RST_RULE_BYTE;
        end else if (clk_en_in && wr_in && offset_in == `OFS_MAC_MID) begin
            mac_mid_q <= wdata_in;
        end
    end

    // RULE6 MAC bits 7:0
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mac_lo_q <= `RST_RULE_BYTE;
        end else if (clk_en_in && wr_in && offset_in == `OFS_MAC_LO) begin
            mac_lo_q <= wdata_in;
        end
    end

    // RULE7 EtherType high byte
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            etype_hi_q <= `RST_RULE_BYTE;
        end else if (clk_en_in && wr_in && offset_in == `OFS_ETYPE_HI) begin
            etype_hi_q <= wdata_in;
        end
    end

    assign rule_out = '{mac_hi: mac_hi_q, mac_mid: mac_mid_q,
                        mac_lo: mac_lo_q, etype_hi: etype_hi_q};

endmodule // acl_l2_port_rule

// ===== testbench/acl_l2_chk.sv
/* Port checker for the ACL layer-2 byte bank.
   Bound to the top module; one clock, asynchronous active-low reset. */
`timescale 1ns/1ps
`include "acl_l2_defines.svh"
module acl_l2_chk #(parameter int NUM_PORTS = 4) (
    // Clock, reset and register port, grouped to keep the file short
    input wire logic                    clk_in, reset_n_in, clk_en_in,
    input wire logic                    reg_wr_in, reg_rd_in, reg_rvalid_out,
    input wire logic [7:0]              reg_addr_in, reg_wdata_in, reg_rdata_out,
    input wire logic [NUM_PORTS*32-1:0] rules_out
);
    logic [7:0] ctl_q;
    logic [7:0] ofs_q;
    logic       wv;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Selected byte; zero whenever the selection is refused
    function automatic logic [7:0] pick(logic [NUM_PORTS*32-1:0] r, logic [7:0] c, logic [7:0] o);
        if (c[7:5] != `TSEL_ACL || c[3:0] == 4'h0 || c[3:0] > NUM_PORTS) return 8'h00;
        if (o < `OFS_MAC_HI || o > `OFS_ETYPE_HI) return 8'h00;
        return r[(int'(c[3:0]) - 1) * 32 + (8 - int'(o)) * 8 +: 8];
    endfunction
    // Mirror of control and offset, so stored bytes can be predicted
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctl_q <= 8'h00;
            ofs_q <= 8'h00;
        end else if (clk_en_in && reg_wr_in) begin
            if (reg_addr_in == `ADDR_TABLE_PORT_SEL) ctl_q <= reg_wdata_in;
            if (reg_addr_in == `ADDR_BYTE_OFFSET) ofs_q <= reg_wdata_in;
        end
    end
    // Data write that the selection allows to land
    assign wv = clk_en_in && reg_wr_in && reg_addr_in == `ADDR_BYTE_DATA
        && ctl_q[7:5] == `TSEL_ACL && ctl_q[3:0] != 4'h0 && ctl_q[3:0] <= NUM_PORTS;
    rvalid_on_read_a: assert property (clk_en_in && reg_rd_in |=> reg_rvalid_out)
        else $error("rvalid missing");
    rvalid_idle_a: assert property (clk_en_in && !reg_rd_in |=> !reg_rvalid_out)
        else $error("stray rvalid");
    read_byte_a: assert property (clk_en_in && reg_rd_in && reg_addr_in == `ADDR_BYTE_DATA
        |=> reg_rdata_out == pick(rules_out, $past(ctl_q), $past(ofs_q))) else $error("bad data");
    mac_hi_store_a: assert property (wv && ofs_q == `OFS_MAC_HI ##1 clk_en_in
        |=> pick(rules_out, $past(ctl_q, 2), `OFS_MAC_HI) == $past(reg_wdata_in, 2))
        else $error("mac hi not stored");
    mac_mid_store_a: assert property (wv && ofs_q == `OFS_MAC_MID ##1 clk_en_in
        |=> pick(rules_out, $past(ctl_q, 2), `OFS_MAC_MID) == $past(reg_wdata_in, 2))
        else $error("mac mid not stored");
    mac_lo_store_a: assert property (wv && ofs_q == `OFS_MAC_LO ##1 clk_en_in
        |=> pick(rules_out, $past(ctl_q, 2), `OFS_MAC_LO) == $past(reg_wdata_in, 2))
        else $error("mac lo not stored");
    etype_store_a: assert property (wv && ofs_q == `OFS_ETYPE_HI ##1 clk_en_in
        |=> pick(rules_out, $past(ctl_q, 2), `OFS_ETYPE_HI) == $past(reg_wdata_in, 2))
        else $error("ethertype not stored");
    rules_hold_a: assert property (clk_en_in && !reg_wr_in ##1 clk_en_in |=> $stable(rules_out))
        else $error("rules changed without write");
endmodule // acl_l2_chk
bind acl_l2_match_indirect_bytes acl_l2_chk #(.NUM_PORTS(NUM_PORTS)) u_acl_l2_chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rvalid_out(reg_rvalid_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .rules_out(rules_out));

// ===== testbench/tb_top.sv
/* Self-checking bench for the ACL layer-2 byte bank.
   Drives the register port directly; the checker is bound separately. */
`timescale 1ns/1ps
`include "acl_l2_defines.svh"
module tb_top;
    logic         clk_in = 0, reset_n_in = 0, clk_en_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    logic [7:0]   reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
    logic         reg_rvalid_out;
    logic [127:0] rules_out;
    logic [7:0]   c, o, d;
    int           fails = 0, checks_done = 0;
    int           mdl [1:4][5:8];
    acl_l2_match_indirect_bytes #(.NUM_PORTS(4)) u_acl_l2_match_indirect_bytes (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .rules_out(rules_out));
    // Free-running 100 MHz clock
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // Compare and count
    task automatic chk(logic [127:0] got, logic [127:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    // One-cycle read strobe; answer is registered one cycle later
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rvalid_out, 1'b1);
        chk(reg_rdata_out, e);
    endtask
    // Model lookup; refused selections read zero
    function automatic logic [7:0] exp_byte(logic [7:0] cc, logic [7:0] oo);
        if (cc[7:5] != `TSEL_ACL || !(cc[3:0] inside {[1:4]}) || !(oo inside {[5:8]})) return 8'h00;
        return 8'(mdl[cc[3:0]][oo]);
    endfunction
    // Closing report
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog, far beyond the expected run of about nine hundred cycles
    initial begin
        #200us;
        fails++;
        $display("ERROR %0t: watchdog expired", $time);
        give_verdict();
    end
    // Main sequence
    initial begin
        void'($urandom(33));
        foreach (mdl[p, f]) mdl[p][f] = 0;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        for (int p = 1; p <= 4; p++) begin
            wr(`ADDR_TABLE_PORT_SEL, {3'h2, 1'b0, 4'(p)});
            for (int f = 5; f <= 8; f++) begin
                wr(`ADDR_BYTE_OFFSET, 8'(f));
                rd(`ADDR_BYTE_DATA, 8'h00); // Reset
            end
        end
        rd(8'h55, 8'h00); // Unmapped
        // only layer-2 bytes, offsets 5 to 8, go into these entries
        // Random selections, including refused tables, ports and offsets
        repeat (60) begin
            c = {($urandom % 4 == 0) ? 3'h1 : 3'h2, 1'b0, 4'($urandom % 6)};
            o = 8'(4 + $urandom % 6);
            d = 8'($urandom);
            wr(`ADDR_TABLE_PORT_SEL, c);
            wr(`ADDR_BYTE_OFFSET, o);
            wr(`ADDR_BYTE_DATA, d);
            if (exp_byte(c, o) !== 8'h00 || (c[7:5] == 3'h2 && c[3:0] inside {[1:4]}
                && o inside {[5:8]})) mdl[c[3:0]][o] = d;
            rd(`ADDR_BYTE_OFFSET, o);
            rd(`ADDR_TABLE_PORT_SEL, c);
            rd(`ADDR_BYTE_DATA, exp_byte(c, o));
            for (int p = 1; p <= 4; p++)
                chk(rules_out[p*32-1 -: 32], {8'(mdl[p][5]), 8'(mdl[p][6]), 8'(mdl[p][7]),
                    8'(mdl[p][8])});
            // Frozen cycle with a data write on the bus; it must be lost
            @(posedge clk_in);
            clk_en_in <= 1'b0;
            reg_wr_in <= 1'b1;
            reg_addr_in <= `ADDR_BYTE_DATA;
            reg_wdata_in <= ~d;
            @(posedge clk_in);
            clk_en_in <= 1'b1;
            reg_wr_in <= 1'b0;
        end
        // Mid-run reset clears every stored byte and the selection
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        foreach (mdl[p, f]) mdl[p][f] = 0;
        chk(rules_out, 128'h0);
        rd(`ADDR_TABLE_PORT_SEL, 8'h00);
        give_verdict();
    end
endmodule // tb_top
